//--- hdl/rst_seq_regs.svh
// register offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RST_SEQ_REGS_SVH
`define RST_SEQ_REGS_SVH

// byte offsets on the register bus
`define OFS_POWER_CONTROL 4'h0
`define OFS_BROWNOUT_CONTROL 4'h4
`define OFS_CORE_STATUS 4'h8
`define OFS_WATCHDOG_CONTROL 4'hC

// power control flag register fields
`define PCF_STACK_OVER 7
`define PCF_STACK_UNDER 6
`define PCF_WDT_RESET 4
`define PCF_PIN_RESET 3
`define PCF_SOFT_RESET 2
`define PCF_POWER_ON 1
`define PCF_BROWNOUT 0
`define PCF_IMPL_MASK 8'hDF

// core status fields
`define CST_EXPIRY 4
`define CST_POWERDOWN 3

// brown-out control fields
`define BRC_SW_ENABLE 7
`define BRC_FAST_START 6
`define BRC_READY 0
`define BRC_RESET 8'h80

// watchdog control: prescale field
`define WDC_RESET 8'h16
`define WDC_MASK 8'h1F

// power-on flag value: 00 -1 110x with brown-out cleared
`define PCF_POR_VALUE 8'h1C

// timing
`define CLK_HZ 20000000
`define POWERUP_TIMER_MS 64
`define POWERUP_TIMER_CYCLES ((`POWERUP_TIMER_MS * `CLK_HZ) / 1000)
`define MASTER_CLEAR_PIN_FILTER_NS 2000
`define MASTER_CLEAR_PIN_FILTER_CYCLES ((`MASTER_CLEAR_PIN_FILTER_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define RESET_VECTOR 16'h0000
`define IRQ_VECTOR 16'h0004

`endif

//--- hdl/rst_seq_pkg.sv
// types shared by the reset sequencer
package rst_seq_pkg;

	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN = 2'b10,
		ST_SLEEP = 2'b11
	} seq_state_e;

	// reset and wake events from the core
	typedef struct packed {
		logic power_on;
		logic brownout;
		logic lp_brownout;
		logic prog_exit;
		logic wdt_timeout;
		logic reset_instr;
		logic stack_over;
		logic stack_under;
		logic irq_wake;
	} core_events_s;

	// static configuration words
	typedef struct packed {
		logic pin_reset_enable;
		logic low_voltage_prog;
		logic powerup_timer_disable_n;
		logic stack_reset_enable;
		logic osc_needs_ost;
	} config_s;

endpackage

//--- hdl/reset_cause_and_startup.sv
// reset source combiner, start-up gate and reset-cause flags with wishbone registers
`timescale 1ns/1ps
`include "rst_seq_regs.svh"

module reset_cause_and_startup
	import rst_seq_pkg::*;
#(
	parameter int POWERUP_TIMER_CYCLES = `POWERUP_TIMER_CYCLES,
	parameter int OST_CYCLES = 1024,
	parameter int FILTER_CYCLES = `MASTER_CLEAR_PIN_FILTER_CYCLES
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// pin and configuration
	input wire logic master_clear_pin_i,
	input wire config_s cfg_i,
	// core events and status
	input wire core_events_s ev_i,
	input wire logic global_irq_enable_i,
	input wire logic sleeping_i,
	input wire logic [15:0] pc_i,
	// results
	output logic core_reset_o,
	output logic pc_load_o,
	output logic [15:0] pc_value_o,
	output logic push_return_o,
	output logic pin_pullup_o,
	output logic pin_gpio_o,
	output logic [4:0] watchdog_prescale_o
);

	// pin synchroniser: first stage feeds only the second
	logic pin_meta_ff, pin_sync_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_ff <= 1'b1;
			pin_sync_ff <= 1'b1;
		end else if (ce_i) begin
			pin_meta_ff <= master_clear_pin_i;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	logic pin_enabled;
	assign pin_enabled = cfg_i.pin_reset_enable | cfg_i.low_voltage_prog;

	// low level must persist for the whole window before it counts
	logic [15:0] filt_cnt_ff;
	logic pin_low_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filt_cnt_ff <= 16'h0000;
			pin_low_ff <= 1'b0;
		end else if (ce_i) begin
			if (pin_sync_ff) begin
				filt_cnt_ff <= 16'h0000;
				pin_low_ff <= 1'b0;
			end else if (filt_cnt_ff >= 16'(FILTER_CYCLES - 1)) begin
				pin_low_ff <= 1'b1;
			end else begin
				filt_cnt_ff <= filt_cnt_ff + 16'h0001;
			end
		end
	end

	logic pin_hold;
	assign pin_hold = pin_enabled & pin_low_ff;

	// pin reset event on the filtered edge
	logic pin_hold_d_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pin_hold_d_ff <= 1'b0;
		else if (ce_i)
			pin_hold_d_ff <= pin_hold;
	end
	logic pin_evt;
	assign pin_evt = pin_hold & ~pin_hold_d_ff;

	// event decode
	logic por_evt, bor_evt, stk_reset, wdt_reset, wdt_wake, irq_wake, any_reset;
	assign por_evt = ev_i.power_on | ev_i.prog_exit;
	assign bor_evt = ev_i.brownout | ev_i.lp_brownout;
	assign stk_reset = cfg_i.stack_reset_enable & (ev_i.stack_over | ev_i.stack_under);
	assign wdt_reset = ev_i.wdt_timeout & ~sleeping_i;
	assign wdt_wake = ev_i.wdt_timeout & sleeping_i;
	assign irq_wake = ev_i.irq_wake & sleeping_i & ~ev_i.wdt_timeout;
	assign any_reset = por_evt | bor_evt | stk_reset | wdt_reset | ev_i.reset_instr | pin_evt;

	// bus decode; one-cycle ack, dropped the cycle after
	logic bus_req, wr_pcf, wr_brc, wr_cst, wr_wdc;
	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign wr_pcf = bus_req & we_i & sel_i[0] & (adr_i == `OFS_POWER_CONTROL);
	assign wr_brc = bus_req & we_i & sel_i[0] & (adr_i == `OFS_BROWNOUT_CONTROL);
	assign wr_cst = bus_req & we_i & sel_i[0] & (adr_i == `OFS_CORE_STATUS);
	assign wr_wdc = bus_req & we_i & sel_i[0] & (adr_i == `OFS_WATCHDOG_CONTROL);

	// power control flags; hardware terms applied after the write so they win
	logic [7:0] pcf_ff;
	logic [7:0] nxt_pcf;
	always_comb begin
		nxt_pcf = pcf_ff;
		if (wr_pcf)
			nxt_pcf = dat_i[7:0] & `PCF_IMPL_MASK;
		if (por_evt) begin
			nxt_pcf = `PCF_POR_VALUE;
		end else begin
			if (bor_evt) begin
				nxt_pcf[`PCF_STACK_OVER] = 1'b0;
				nxt_pcf[`PCF_STACK_UNDER] = 1'b0;
				nxt_pcf[`PCF_PIN_RESET] = 1'b1;
				nxt_pcf[`PCF_SOFT_RESET] = 1'b1;
				nxt_pcf[`PCF_BROWNOUT] = 1'b0;
			end
			if (wdt_reset)
				nxt_pcf[`PCF_WDT_RESET] = 1'b0;
			if (pin_evt)
				nxt_pcf[`PCF_PIN_RESET] = 1'b0;
			if (ev_i.reset_instr)
				nxt_pcf[`PCF_SOFT_RESET] = 1'b0;
			if (ev_i.stack_over)
				nxt_pcf[`PCF_STACK_OVER] = 1'b1;
			if (ev_i.stack_under)
				nxt_pcf[`PCF_STACK_UNDER] = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pcf_ff <= `PCF_POR_VALUE;
		else if (ce_i)
			pcf_ff <= nxt_pcf;
	end

	// expiry and powerdown flags of the core status register
	logic expiry_ff, powerdown_ff, nxt_expiry, nxt_powerdown;
	always_comb begin
		nxt_expiry = expiry_ff;
		nxt_powerdown = powerdown_ff;
		if (wr_cst) begin
			nxt_expiry = dat_i[`CST_EXPIRY];
			nxt_powerdown = dat_i[`CST_POWERDOWN];
		end
		if (por_evt | bor_evt) begin
			nxt_expiry = 1'b1;
			nxt_powerdown = 1'b1;
		end else if (wdt_reset) begin
			nxt_expiry = 1'b0;
		end else if (wdt_wake) begin
			nxt_expiry = 1'b0;
			nxt_powerdown = 1'b0;
		end else if (pin_evt & sleeping_i) begin
			nxt_expiry = 1'b1;
			nxt_powerdown = 1'b0;
		end else if (irq_wake) begin
			nxt_expiry = 1'b1;
			nxt_powerdown = 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			expiry_ff <= 1'b1;
			powerdown_ff <= 1'b1;
		end else if (ce_i) begin
			expiry_ff <= nxt_expiry;
			powerdown_ff <= nxt_powerdown;
		end
	end

	// brown-out control and watchdog prescale, plus software pull-up
	logic [7:0] brc_ff;
	logic [4:0] wdc_ff;
	logic pullup_sw_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brc_ff <= `BRC_RESET;
			wdc_ff <= 5'(`WDC_RESET);
			pullup_sw_ff <= 1'b1;
		end else if (ce_i) begin
			if (wr_brc) begin
				brc_ff[`BRC_SW_ENABLE] <= dat_i[`BRC_SW_ENABLE];
				brc_ff[`BRC_FAST_START] <= dat_i[`BRC_FAST_START];
				pullup_sw_ff <= dat_i[1];
			end
			if (wr_wdc)
				wdc_ff <= dat_i[4:0];
		end
	end

	// start-up timers; both run regardless of the pin
	logic [31:0] powerup_timer_cnt_ff;
	logic [31:0] ost_cnt_ff;
	logic powerup_timer_done, ost_done;
	assign powerup_timer_done = cfg_i.powerup_timer_disable_n | (powerup_timer_cnt_ff == 32'h0000_0000);
	assign ost_done = ~cfg_i.osc_needs_ost | (ost_cnt_ff == 32'h0000_0000);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			powerup_timer_cnt_ff <= 32'(POWERUP_TIMER_CYCLES);
			ost_cnt_ff <= 32'(OST_CYCLES);
		end else if (ce_i) begin
			if (por_evt | bor_evt) begin
				powerup_timer_cnt_ff <= 32'(POWERUP_TIMER_CYCLES);
				ost_cnt_ff <= 32'(OST_CYCLES);
			end else begin
				if (powerup_timer_cnt_ff != 32'h0000_0000)
					powerup_timer_cnt_ff <= powerup_timer_cnt_ff - 32'h0000_0001;
				if (ost_cnt_ff != 32'h0000_0000)
					ost_cnt_ff <= ost_cnt_ff - 32'h0000_0001;
			end
		end
	end

	// sequencer
	seq_state_e state_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_HOLD;
		end else if (ce_i) begin
			if (por_evt | bor_evt)
				state_ff <= ST_HOLD;
			else if (any_reset && (state_ff != ST_HOLD))
				state_ff <= ST_WAIT; // a pin event waits only for the pin release in ST_WAIT, not for the start-up timers
			else begin
				unique case (state_ff)
					ST_HOLD: if (powerup_timer_done & ost_done & ~pin_hold) state_ff <= ST_RUN;
					ST_WAIT: if (~pin_hold) state_ff <= ST_RUN;
					ST_RUN: if (sleeping_i) state_ff <= ST_SLEEP;
					ST_SLEEP: if (wdt_wake | irq_wake | ~sleeping_i) state_ff <= ST_RUN;
				endcase
			end
		end
	end

	// core outputs: reset level, vector load on a reset event or wake
	logic in_reset;
	assign in_reset = (state_ff == ST_HOLD) | (state_ff == ST_WAIT);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_reset_o <= 1'b1;
			pc_load_o <= 1'b0;
			pc_value_o <= `RESET_VECTOR;
			push_return_o <= 1'b0;
		end else if (ce_i) begin
			core_reset_o <= in_reset | any_reset;
			pc_load_o <= 1'b0;
			push_return_o <= 1'b0;
			if (any_reset) begin
				pc_load_o <= 1'b1;
				pc_value_o <= `RESET_VECTOR;
			end else if (wdt_wake) begin
				pc_load_o <= 1'b1;
				pc_value_o <= pc_i + 16'h0001;
			end else if (irq_wake) begin
				pc_load_o <= 1'b1;
				push_return_o <= global_irq_enable_i;
				pc_value_o <= global_irq_enable_i ? `IRQ_VECTOR : pc_i + 16'h0001;
			end
		end
	end

	// pin function and pull-up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_pullup_o <= 1'b1;
			pin_gpio_o <= 1'b1;
		end else if (ce_i) begin
			pin_pullup_o <= pin_enabled | pullup_sw_ff;
			pin_gpio_o <= pin_sync_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			watchdog_prescale_o <= 5'(`WDC_RESET);
		else if (ce_i)
			watchdog_prescale_o <= wdc_ff;
	end

	// bus read data; unmapped addresses read zero and are still acked
	logic [7:0] rd_byte;
	always_comb begin
		unique case (adr_i)
			`OFS_POWER_CONTROL: rd_byte = pcf_ff & `PCF_IMPL_MASK;
			`OFS_BROWNOUT_CONTROL: rd_byte = {brc_ff[7:6], 4'h0, pullup_sw_ff, 1'b1};
			`OFS_CORE_STATUS: rd_byte = {3'h0, expiry_ff, powerdown_ff, 3'h0};
			`OFS_WATCHDOG_CONTROL: rd_byte = {3'h0, wdc_ff};
			default: rd_byte = 8'h00;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_o <= bus_req;
			if (bus_req)
				dat_o <= {24'h00_0000, rd_byte};
		end
	end

endmodule

//--- verification/rst_seq_properties.sv
// port-level property checker of the reset sequencer
`timescale 1ns/1ps
module rst_seq_properties
	import rst_seq_pkg::*;
#(
	parameter int FILTER_CYCLES = 4
) (
	// clock and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// pin, configuration, events
	input wire logic master_clear_pin_i,
	input wire config_s cfg_i,
	input wire core_events_s ev_i,
	// results
	input wire logic core_reset_o,
	input wire logic pc_load_o,
	input wire logic [15:0] pc_value_o,
	input wire logic push_return_o,
	input wire logic pin_gpio_o
);
	int low_cnt;
	logic pin_en;
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// pin reset is live when either configuration bit asks for it
	assign pin_en = cfg_i.pin_reset_enable | cfg_i.low_voltage_prog;
	// saturating length of an enabled low level, so long holds never wrap
	always_ff @(posedge clk_i) begin
		if (rst_i || master_clear_pin_i || !pin_en) begin
			low_cnt <= 0;
		end else if (low_cnt < 255) begin
			low_cnt <= low_cnt + 1;
		end
	end
	ack_next_cycle_a: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
		else $error("ack missing");
	ack_single_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	bit_five_zero_a: assert property (ack_o && !we_i && adr_i == 4'h0 |-> !dat_o[5])
		else $error("bit five set");
	instr_reset_pc_a: assert property (ev_i.reset_instr |->
		##[1:2] (pc_load_o && pc_value_o == 16'h0000 && core_reset_o)) else $error("no reset");
	stack_no_reset_a: assert property ((ev_i.stack_over || ev_i.stack_under) &&
		!cfg_i.stack_reset_enable && !core_reset_o |=> !core_reset_o [*3]) else $error("stack");
	wake_vector_a: assert property (push_return_o |-> pc_load_o && pc_value_o == 16'h0004)
		else $error("bad vector");
	pin_holds_reset_a: assert property (low_cnt > FILTER_CYCLES + 4 |-> core_reset_o)
		else $error("pin low without reset");
	pin_filter_a: assert property (pin_en && !core_reset_o && $fell(master_clear_pin_i)
		##1 !master_clear_pin_i ##1 master_clear_pin_i |=> !core_reset_o [*6]) else $error("glitch");
	gpio_follows_pin_a: assert property ((!pin_en && !master_clear_pin_i) [*5] |-> !pin_gpio_o)
		else $error("gpio stale");
	powerup_timer_hold_a: assert property (ev_i.power_on && !cfg_i.powerup_timer_disable_n
		|-> ##2 core_reset_o [*8]) else $error("early start");
	cover property (ack_o && we_i);
	cover property (push_return_o);
	cover property ($fell(core_reset_o));
endmodule

//--- verification/pin_driver_model.sv
// external reset pin driver
`timescale 1ns/1ps
module pin_driver_model (
	// request from the bench
	input wire logic drive_low_i,
	// pin level seen by the device
	output logic pin_o
);
	// released pin is driven high by the model, never floats
	assign pin_o = drive_low_i ? 1'b0 : 1'b1;
endmodule

//--- verification/tb_top.sv
// self-checking bench of the reset sequencer with a flag model
`timescale 1ns/1ps
module tb_top
	import rst_seq_pkg::*;
;
	localparam int PW = 20;
	logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic ack_o, pin, drv = 0, global_irq_enable = 0, slp = 0, tm, pd, rs;
	logic core_reset_o, pc_load_o, push_return_o, pin_pullup_o, pin_gpio_o;
	logic [3:0] adr_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic [15:0] pc_i = 0, pc_value_o;
	logic [7:0] pm, w;
	logic [4:0] wps;
	logic [16:0] q[$];
	logic [12:0] sl = 13'hA20;
	int eb[13] = '{8, 5, 7, 6, 4, 4, 3, 2, 1, 0, 9, 9, 10};
	int errors = 0, n_checks = 0, n;
	config_s cfg = '0;
	core_events_s ev = '0;
	// short timers keep the run brief
	reset_cause_and_startup #(.POWERUP_TIMER_CYCLES(PW), .OST_CYCLES(8), .FILTER_CYCLES(4)) dut (
		.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i,
		.dat_o, .ack_o, .master_clear_pin_i(pin), .cfg_i(cfg), .ev_i(ev),
		.global_irq_enable_i(global_irq_enable), .sleeping_i(slp), .pc_i, .core_reset_o, .pc_load_o,
		.pc_value_o, .push_return_o, .pin_pullup_o, .pin_gpio_o, .watchdog_prescale_o(wps));
	pin_driver_model pdrv (.drive_low_i(drv), .pin_o(pin));
	// 20 MHz clock
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	// program counter loads, kept for the reset and wake checks
	always @(posedge clk_i) begin
		if (pc_load_o === 1'b1) q.push_back({push_return_o, pc_value_o});
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// classic single cycle; held until ack is sampled high
	task automatic wb(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= wr;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		if (k >= 50) errors++;
	endtask
	task automatic wait_run();
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (core_reset_o !== 1'b0 && n < 300);
	endtask
	// one reset or wake source, expected flags worked out alongside
	task automatic fire(input int e, input logic en, input logic stv);
		int b;
		b = eb[e];
		w = 8'($urandom()) | 8'h20;
		wb(1, 4'h0, w);
		wb(1, 4'h8, 8'h18);
		pm = w & 8'hDF;
		{tm, pd} = 2'b11;
		q.delete();
		@(posedge clk_i);
		slp <= sl[e];
		pc_i <= 16'($urandom());
		if (b < 9) ev <= core_events_s'(9'h1 << b);
		else drv <= 1;
		repeat (b == 9 ? 12 : (b == 10 ? 2 : 1)) @(posedge clk_i);
		if (b == 9) chk({pin_gpio_o, core_reset_o}, {1'b0, en});
		ev <= '0;
		drv <= 0;
		slp <= 0;
		rs = (b == 9 && en) || (b inside {1, 2} && stv) || (b inside {[3:8]} && !sl[e]);
		if (b inside {5, 8}) pm = 8'h1C;
		if (b inside {6, 7}) pm = pm & 8'h12 | 8'h0C;
		if (b == 4 && !sl[e]) pm[4] = 0;
		if (b == 3) pm[2] = 0;
		if (b == 2) pm[7] = 1;
		if (b == 1) pm[6] = 1;
		if (b == 9 && en) pm[3] = 0;
		if (b == 4) {tm, pd} = {1'b0, pd & !sl[e]};
		if (b == 0 || (b == 9 && en && sl[e])) {tm, pd} = 2'b10;
		repeat (6) @(posedge clk_i);
		wait_run();
		wb(0, 4'h0, 0);
		chk(rd, {24'h0, pm});
		wb(0, 4'h8, 0);
		chk(rd & 32'h18, {27'h0, tm, pd, 3'h0});
		if (rs) chk(q.size() ? q[0] : 17'h1FFFF, 0);
		else if (b == 0) chk(q.size() ? q[$] : 0, global_irq_enable ? 17'h10004 : {1'b0, pc_i + 16'h1});
		else if (b == 4 && sl[e]) chk(q.size() ? q[0] : 0, {1'b0, pc_i + 16'h1});
		else if (b != 0 && !(b == 4 && sl[e])) chk(q.size(), 0);
	endtask
	// pin enabled by either bit, then pin off with timers off
	initial begin
		n = $urandom(62);
		for (int p = 0; p < 3; p++) begin
			cfg <= {p == 0, p == 1, p == 2, p == 1, p != 2};
			global_irq_enable <= p != 2;
			rst_i <= 1;
			repeat (10) @(posedge clk_i);
			rst_i <= 0;
			wait_run();
			chk({core_reset_o, n < PW}, {1'b0, p == 2});
			wb(0, 4'h0, 0);
			chk(rd, 32'h1C);
			wb(0, 4'h8, 0);
			chk(rd & 32'h18, 32'h18);
			wb(0, 4'h2, 0);
			chk(rd, 0);
			w = 8'($urandom());
			wb(1, 4'h4, w);
			wb(1, 4'hC, w);
			wb(0, 4'h4, 0);
			chk(rd, {24'h0, w & 8'hC2 | 8'h01});
			wb(0, 4'hC, 0);
			chk(rd, {27'h0, w[4:0]});
			chk({pin_pullup_o, wps}, {p == 2 ? w[1] : 1'b1, w[4:0]});
			for (int e = 0; e < 13; e++) fire(e, p != 2, p == 1);
			if (p == 0) begin
				drv <= 1;
				ev <= core_events_s'(9'h100);
				@(posedge clk_i);
				ev <= '0;
				repeat (40) @(posedge clk_i);
				chk(core_reset_o, 1);
				drv <= 0;
				wait_run();
				chk(n <= 6, 1);
			end
		end
		finish_test();
	end
	// hang guard, well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		finish_test();
	end
endmodule
bind reset_cause_and_startup rst_seq_properties #(.FILTER_CYCLES(FILTER_CYCLES)) props (
	.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .master_clear_pin_i,
	.cfg_i, .ev_i, .core_reset_o, .pc_load_o, .pc_value_o, .push_return_o, .pin_gpio_o);
